//--- verilog/ppmc_regs.sv
// power management and msg_interrupt_header registers of one switch port
// What this block does
// RULE1: power_capability_header id byte always reads 01h
// RULE2: pm next pointer resets 5Ch upstream, 4Ch downstream
// RULE3: pm revision field 18:16 reads 011b
// RULE4: pme clock bit 19 and bridge bits 22, 23 read zero
// RULE5: device specific initialisation bit 21 reads zero by default
// RULE6: aux current field 24:22 resets to 111b
// RULE7: d1 and d2 support bits 25, 26 read one by default
// RULE8: pme support field 31:27 reads all ones by default
// RULE9: listed read-only defaults can be loaded from sideband or eeprom
// RULE10: power state 1:0 is read/write, resets to d0
// RULE11: d3hot to d0 write causes hot reset, downstream reset untouched
// RULE12: no-soft-reset bit resets one; clear means internal reset
// RULE13: sticky pme enable bit 8 resets zero and enables pme messages
// RULE14: data select rw, data scale ro, data byte ro loadable
// RULE15: sticky pme status bit 15 always reads zero
// RULE16: msg_interrupt_header only downstream; id 05h, next pointer 64h
// RULE17: msi enable bit 16 resets zero; one selects msi, blocks intx
// RULE18: 64-bit capable bit 23 resets one
// RULE19: message address 31:2 rw, 1:0 reserved, used when msi enabled
// RULE20: multiple message capable reads zero, enable field is rw
`timescale 1ns/10ps
`include "ppmc_params.svh"
module ppmc_regs
   import ppmc_pkg::*;
#(
   parameter bit IS_UPSTREAM = 1'b0
) (
   input wire logic clk, // core clock, 25 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic sticky_rst, // power-on reset of sticky bits
   input wire logic cfg_wr, // config write strobe
   input wire logic cfg_rd, // config read strobe
   input wire logic [7:0] cfg_addr, // config byte address, dword aligned
   input wire logic [3:0] cfg_be, // write byte enables
   input wire logic [31:0] cfg_wdata, // write data
   output logic [31:0] cfg_rdata, // read data, registered
   input wire logic dflt_wr, // sideband/eeprom default load strobe
   input wire logic [7:0] dflt_addr, // sideband target dword address
   input wire logic [31:0] dflt_data, // sideband default values
   input wire logic pme_event, // port wants to raise a pme
   input wire logic irq_event, // port wants to raise an interrupt
   output logic pme_msg_req, // one-cycle request for a pme message
   output logic msi_req, // one-cycle request for an msi write
   output logic [31:0] msi_addr, // address of the msi write
   output logic intx_req, // one-cycle legacy interrupt request
   output logic hot_reset, // one-cycle hot reset of the port
   output logic internal_reset, // one-cycle internal reset
   output logic downstream_port_reset_out // never pulsed by pm writes
);
   logic is_dn;
   logic [1:0] pstate_reg;
   logic [1:0] pstate_next;
   logic pme_en_reg;
   logic [3:0] dsel_reg;
   logic msi_en_reg;
   logic [2:0] mme_reg;
   logic [29:0] addr_reg;
   logic dsi_reg;
   logic [2:0] aux_reg;
   logic d1_reg;
   logic d2_reg;
   logic [4:0] pme_sup_reg;
   logic nsr_reg;
   logic [7:0] data_reg;
   logic wr_csr;
   logic wr_msi;
   logic wake;

   assign is_dn = !IS_UPSTREAM;
   assign wr_csr = cfg_wr && cfg_addr == `PPMC_OFS_PM_CSR;
   // msi registers do not exist on the upstream port
   assign wr_msi = cfg_wr && is_dn; // RULE16
   assign pstate_next = cfg_wdata[`PPMC_PS_LSB +: 2];
   assign wake = wr_csr && cfg_be[0] && pstate_reg == PPMC_D3HOT
      && pstate_next == PPMC_D0;

   // read-only defaults replaced by the sideband or eeprom loader
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dsi_reg <= `PPMC_RST_DSI; // RULE5
         aux_reg <= `PPMC_RST_AUX; // RULE6
         d1_reg <= `PPMC_RST_D1; // RULE7
         d2_reg <= `PPMC_RST_D2; // RULE7
         pme_sup_reg <= `PPMC_RST_PME_SUP; // RULE8
         nsr_reg <= `PPMC_RST_NSR; // RULE12
         data_reg <= `PPMC_RST_DATA; // RULE14
      end else if (dflt_wr && dflt_addr == `PPMC_OFS_PM_CAP) begin
         dsi_reg <= dflt_data[21]; // RULE9
         aux_reg <= dflt_data[24:22];
         d1_reg <= dflt_data[25];
         d2_reg <= dflt_data[26];
         pme_sup_reg <= dflt_data[31:27];
      end else if (dflt_wr && dflt_addr == `PPMC_OFS_PM_CSR) begin
         nsr_reg <= dflt_data[`PPMC_NSR_BIT]; // RULE9
         data_reg <= dflt_data[31:24];
      end
   end

   // power state and data select; only the plain reset sys_rst clears them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pstate_reg <= PPMC_D0; // RULE10
         dsel_reg <= 4'h0; // RULE14
      end else if (wr_csr) begin
         if (cfg_be[0]) begin
            pstate_reg <= pstate_next; // RULE10
         end
         if (cfg_be[1]) begin
            dsel_reg <= cfg_wdata[`PPMC_DSEL_LSB +: 4]; // RULE14
         end
      end
   end

   // pme enable is sticky: only the power-on reset clears it
   always_ff @(posedge clk) begin
      if (sticky_rst) begin
         pme_en_reg <= 1'b0; // RULE13
      end else if (wr_csr && cfg_be[1]) begin
         pme_en_reg <= cfg_wdata[`PPMC_PMEEN_BIT]; // RULE13
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         msi_en_reg <= 1'b0; // RULE17
         mme_reg <= 3'h0; // RULE20
         addr_reg <= 30'h0; // RULE19
      end else begin
         if (wr_msi && cfg_addr == `PPMC_OFS_MSI_CAP && cfg_be[2]) begin
            msi_en_reg <= cfg_wdata[`PPMC_MSIEN_BIT]; // RULE17
            mme_reg <= cfg_wdata[`PPMC_MME_LSB +: 3]; // RULE20
         end
         if (wr_msi && cfg_addr == `PPMC_OFS_MSI_ADDR) begin
            // the register holds bits 31:2, so byte lanes sit two bits lower
            if (cfg_be[0]) begin
               addr_reg[5:0] <= cfg_wdata[7:2]; // RULE19
            end
            for (int i = 1; i < 4; i++) begin
               if (cfg_be[i]) begin
                  addr_reg[i*8-2 +: 8] <= cfg_wdata[i*8 +: 8]; // RULE19
               end
            end
         end
      end
   end

   // reset pulses of a d3hot to d0 write; downstream pin never driven here
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hot_reset <= 1'b0;
         internal_reset <= 1'b0;
      end else begin
         hot_reset <= wake; // RULE11
         internal_reset <= wake && !nsr_reg; // RULE12
      end
   end
   assign downstream_port_reset_out = 1'b0; // RULE11

   // event requests; msi steers interrupts away from intx
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pme_msg_req <= 1'b0;
         msi_req <= 1'b0;
         intx_req <= 1'b0;
      end else begin
         pme_msg_req <= pme_event && pme_en_reg; // RULE13
         msi_req <= irq_event && is_dn && msi_en_reg; // RULE17
         intx_req <= irq_event && !(is_dn && msi_en_reg); // RULE17
      end
   end
   assign msi_addr = {addr_reg, 2'b00}; // RULE19

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_rdata <= 32'h0;
      end else if (cfg_rd) begin
         unique case (cfg_addr)
            `PPMC_OFS_PM_CAP: cfg_rdata <= {pme_sup_reg, d2_reg, d1_reg,
               aux_reg, dsi_reg, 1'b0, 1'b0, `PPMC_PM_REV, // RULE4 RULE3
               (is_dn ? `PPMC_PM_NEXT_DN : `PPMC_PM_NEXT_UP), // RULE2
               `PPMC_PM_CAP_ID}; // RULE1
            `PPMC_OFS_PM_CSR: cfg_rdata <= {data_reg, 2'b00, 6'h00,
               1'b0, 2'b00, dsel_reg, pme_en_reg, // RULE15 RULE4
               4'h0, nsr_reg, 1'b0, pstate_reg}; // RULE14
            `PPMC_OFS_MSI_CAP: cfg_rdata <= is_dn ? {8'h00, 1'b1, mme_reg,
               3'h0, msi_en_reg, `PPMC_MSI_NEXT, // RULE18 RULE20
               `PPMC_MSI_CAP_ID} : 32'h0; // RULE16
            `PPMC_OFS_MSI_ADDR: cfg_rdata <= is_dn ?
               {addr_reg, 2'b00} : 32'h0; // RULE19
            default: cfg_rdata <= 32'h0;
         endcase
      end
   end

   pm_cap_id_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == `PPMC_OFS_PM_CAP |=>
      cfg_rdata[7:0] == 8'h01 && cfg_rdata[18:16] == 3'h3
      && cfg_rdata[19] == 1'b0) else $error("pm id/rev wrong"); // RULE1
   pm_next_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == `PPMC_OFS_PM_CAP |=>
      cfg_rdata[15:8] == (IS_UPSTREAM ? 8'h5C : 8'h4C))
      else $error("pm next pointer wrong"); // RULE2
   pme_stat_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == `PPMC_OFS_PM_CSR |=>
      cfg_rdata[15] == 1'b0 && cfg_rdata[23:22] == 2'b00)
      else $error("pme status or bridge bits set"); // RULE15
   pstate_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_csr && cfg_be[0] ##1 cfg_rd && cfg_addr == `PPMC_OFS_PM_CSR |=>
      cfg_rdata[1:0] == $past(cfg_wdata[1:0], 2))
      else $error("power state not stored"); // RULE10
   hot_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
      wake |=> hot_reset && !downstream_port_reset_out)
      else $error("missing hot reset"); // RULE11
   soft_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
      hot_reset |-> internal_reset == !$past(nsr_reg))
      else $error("internal reset wrong"); // RULE12
   pme_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      pme_msg_req |-> $past(pme_en_reg) && $past(pme_event))
      else $error("pme without enable"); // RULE13
   msi_intx_a: assert property (@(posedge clk) disable iff (sys_rst)
      !(msi_req && intx_req)) else $error("msi and intx together"); // RULE17
   msi_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == `PPMC_OFS_MSI_CAP && is_dn |=>
      cfg_rdata[7:0] == 8'h05 && cfg_rdata[15:8] == 8'h64
      && cfg_rdata[23] && cfg_rdata[19:17] == 3'h0)
      else $error("msi header wrong"); // RULE18

   // hardwired and reserved bits of the power capability dword
   pm_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
      cfg_rd && cfg_addr == `PPMC_OFS_PM_CAP |=>
      cfg_rdata[20] == 1'b0 && cfg_rdata[19] == 1'b0)
      else $error("power_capability_header reserved bits set");

   // reserved and scale bits of the control/status dword
   csr_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
      cfg_rd && cfg_addr == `PPMC_OFS_PM_CSR |=>
      cfg_rdata[2] == 1'b0 && cfg_rdata[7:4] == 4'h0
      && cfg_rdata[14:13] == 2'b00 && cfg_rdata[21:16] == 6'h00)
      else $error("pm csr reserved bits set");

   // defaults come back on every plain reset
   dflt_reset_a: assert property (@(posedge clk) // RULE6
      sys_rst |=> aux_reg == `PPMC_RST_AUX && d1_reg && d2_reg
      && pme_sup_reg == `PPMC_RST_PME_SUP && dsi_reg == `PPMC_RST_DSI
      && nsr_reg == `PPMC_RST_NSR && data_reg == `PPMC_RST_DATA)
      else $error("defaults not restored");

   // sideband load of the aux, pme support and dsi fields of the capability dword
   dflt_cap_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
      dflt_wr && dflt_addr == `PPMC_OFS_PM_CAP |=>
      aux_reg == $past(dflt_data[24:22])
      && pme_sup_reg == $past(dflt_data[31:27])
      && dsi_reg == $past(dflt_data[21]))
      else $error("capability defaults not loaded");

   // sideband load of no-soft-reset and the data byte
   dflt_csr_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
      dflt_wr && dflt_addr == `PPMC_OFS_PM_CSR |=>
      data_reg == $past(dflt_data[31:24])
      && nsr_reg == $past(dflt_data[3]))
      else $error("csr defaults not loaded");

   pstate_rst_a: assert property (@(posedge clk) // RULE10
      sys_rst |=> pstate_reg == PPMC_D0 && dsel_reg == 4'h0)
      else $error("power state not reset");

   // a plain reset must leave the sticky enable alone
   pme_sticky_a: assert property (@(posedge clk) // RULE13
      sys_rst && !sticky_rst && !wr_csr |=> $stable(pme_en_reg))
      else $error("pme enable lost on plain reset");

   internal_hot_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
      internal_reset |-> hot_reset)
      else $error("internal reset without hot reset");

   // upstream port shows no msi registers
   msi_absent_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
      cfg_rd && !is_dn && (cfg_addr == `PPMC_OFS_MSI_CAP
      || cfg_addr == `PPMC_OFS_MSI_ADDR) |=> cfg_rdata == 32'h0)
      else $error("msi registers seen upstream");

   msi_ctrl_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE20
      wr_msi && cfg_addr == `PPMC_OFS_MSI_CAP && cfg_be[2] |=>
      mme_reg == $past(cfg_wdata[22:20])
      && msi_en_reg == $past(cfg_wdata[16]))
      else $error("msi control not stored");

   intx_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
      intx_req |-> $past(irq_event) && !$past(is_dn && msi_en_reg))
      else $error("intx while msi enabled");

   msi_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
      msi_req |-> $past(msi_en_reg) && msi_addr[1:0] == 2'b00)
      else $error("msi request without enable");
endmodule // ppmc_regs

//--- verilog/ppmc_params.svh
// offsets, field positions and reset values of the port power/msi registers
`ifndef PPMC_PARAMS_SVH
`define PPMC_PARAMS_SVH
`define PPMC_OFS_PM_CAP 8'h40
`define PPMC_OFS_PM_CSR 8'h44
`define PPMC_OFS_MSI_CAP 8'h4C
`define PPMC_OFS_MSI_ADDR 8'h50
`define PPMC_PM_CAP_ID 8'h01
`define PPMC_PM_NEXT_UP 8'h5C
`define PPMC_PM_NEXT_DN 8'h4C
`define PPMC_PM_REV 3'h3
`define PPMC_MSI_CAP_ID 8'h05
`define PPMC_MSI_NEXT 8'h64
`define PPMC_RST_DSI 1'h0
`define PPMC_RST_AUX 3'h7
`define PPMC_RST_D1 1'h1
`define PPMC_RST_D2 1'h1
`define PPMC_RST_PME_SUP 5'h1F
`define PPMC_RST_NSR 1'h1
`define PPMC_RST_DATA 8'h00
`define PPMC_PS_LSB 0
`define PPMC_NSR_BIT 3
`define PPMC_PMEEN_BIT 8
`define PPMC_DSEL_LSB 9
`define PPMC_MSIEN_BIT 16
`define PPMC_MME_LSB 20
`define PPMC_ADDR_LSB 2
`endif

//--- verilog/ppmc_pkg.sv
// types shared by the port power/msg_interrupt_header registers
package ppmc_pkg;
   typedef enum logic [1:0] {
      PPMC_D0 = 2'b00,
      PPMC_D1 = 2'b01,
      PPMC_D2 = 2'b10,
      PPMC_D3HOT = 2'b11
   } ppmc_pstate_e;
endpackage

//--- verif/ppmc_regs_tb_top.sv
// self-checking testbench of the port power/msg_interrupt_header registers
`timescale 1ns/10ps
module ppmc_regs_tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sticky_rst = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic dflt_wr = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [7:0] dflt_addr = 8'h00;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] dflt_data = 32'h0;
   logic pme_event = 1'b0;
   logic irq_event = 1'b0;
   logic [31:0] cfg_rdata;
   logic [31:0] msi_addr;
   logic pme_msg_req, msi_req, intx_req, hot_reset, internal_reset;
   logic downstream_port_reset_out;
   logic [5:0] pulses;
   logic [31:0] up_rdata;
   int fail_count = 0;
   int checked = 0;

   always #20 clk = ~clk;

   // downstream port: both capabilities present
   ppmc_regs ppmc_regs_i (.clk, .sys_rst, .sticky_rst, .cfg_wr, .cfg_rd,
      .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .dflt_wr, .dflt_addr,
      .dflt_data, .pme_event, .irq_event, .pme_msg_req, .msi_req,
      .msi_addr, .intx_req, .hot_reset, .internal_reset,
      .downstream_port_reset_out);

   // upstream port: no msi, other next pointer
   ppmc_regs #(.IS_UPSTREAM(1'b1)) up_ppmc_regs_i (.clk, .sys_rst,
      .sticky_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_rdata(up_rdata), .dflt_wr, .dflt_addr, .dflt_data, .pme_event,
      .irq_event, .pme_msg_req(), .msi_req(), .msi_addr(), .intx_req(),
      .hot_reset(), .internal_reset(), .downstream_port_reset_out());

   assign pulses = {downstream_port_reset_out, internal_reset, hot_reset,
      pme_msg_req, msi_req, intx_req};

   task give_verdict;
      if (fail_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // pulses are looked at in the one cycle they stand
   task chp(input logic [5:0] exp);
      chk("pulses", {26'h0, exp}, {26'h0, pulses});
   endtask

   task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      #1;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      chk("cfg_rdata", exp, cfg_rdata);
   endtask

   task ld(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      dflt_wr <= 1'b1;
      dflt_addr <= a;
      dflt_data <= d;
      @(posedge clk);
      dflt_wr <= 1'b0;
      #1;
   endtask

   task evt(input logic p, input logic i);
      @(posedge clk);
      pme_event <= p;
      irq_event <= i;
      @(posedge clk);
      pme_event <= 1'b0;
      irq_event <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      sticky_rst <= 1'b0;
      rd(8'h40, 32'hFFC34C01);
      chk("up_rdata", 32'hFFC35C01, up_rdata);
      rd(8'h44, 32'h00000008);
      rd(8'h4C, 32'h00806405);
      chk("up_rdata", 32'h0, up_rdata);
      rd(8'h50, 32'h0);
      rd(8'h48, 32'h0);
      chp(6'h00);
      // read-only header must ignore writes
      wr(8'h40, 4'hF, 32'hFFFFFFFF);
      rd(8'h40, 32'hFFC34C01);
      wr(8'h44, 4'hF, 32'hFFFFFFFF);
      chp(6'h00);
      rd(8'h44, 32'h00001F0B);
      evt(1'b1, 1'b0);
      chp(6'h04);
      wr(8'h44, 4'h1, 32'h0);
      chp(6'h08);
      ld(8'h44, 32'hA5000000);
      rd(8'h44, 32'hA5001F00);
      wr(8'h44, 4'h1, 32'h3);
      wr(8'h44, 4'h1, 32'h0);
      chp(6'h18);
      // leaving d1 is no hot reset
      wr(8'h44, 4'h1, 32'h1);
      wr(8'h44, 4'h1, 32'h0);
      chp(6'h00);
      ld(8'h40, 32'h00200000);
      rd(8'h40, 32'h00234C01);
      evt(1'b0, 1'b1);
      chp(6'h01);
      wr(8'h4C, 4'hF, 32'hFFFFFFFF);
      rd(8'h4C, 32'h00F16405);
      wr(8'h50, 4'hF, 32'hFFFFFFFF);
      rd(8'h50, 32'hFFFFFFFC);
      chk("up_rdata", 32'h0, up_rdata);
      chk("msi_addr", 32'hFFFFFFFC, msi_addr);
      evt(1'b0, 1'b1);
      chp(6'h02);
      // plain reset keeps pme enable, reloads defaults
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h44, 32'h00000108);
      rd(8'h4C, 32'h00806405);
      rd(8'h50, 32'h0);
      give_verdict;
   end

   initial begin
      #100000;
      fail_count++;
      give_verdict;
   end
endmodule // ppmc_regs_tb_top
